// >>> hw/cev_exc_unit.sv
// Purpose: exception decision, vectoring and state save for one core
// Assumes: core presents one retiring instruction per cycle in cin
// Notes: registers on AHB-Lite, zero wait states, always OKAY
//
// The AHB-Lite interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ns
// Functional notes
// RQ1 - alignment fault vectors to 0x600, records cause and faulting address
// RQ2 - fp enabled exception when mode bits nonzero and summary bit set
// RQ3 - illegal opcode or absent optional instruction raises program interrupt; code raises none for an absent one flagged opt_nop
// RQ4 - supervisor-only instruction in user mode raises program interrupt
// RQ5 - trap instruction with a true condition raises program interrupt
// RQ6 - fixed variant: fp status move enabling a set exception traps
// RQ7 - programmable variant: unimplemented or illegal cause in syndrome word
// RQ8 - fp instruction with fp unavailable vectors to 0x800
// RQ9 - counter msb rising sets pending; taken at 0x900 when enabled
// RQ10 - programmable variant: counter 1 to 0 reloads and sets status
// RQ11 - system call vectors to 0xC00
// RQ12 - trace at 0xD00 on single step completion or branch trace
// RQ13 - optional fp assist interrupt at 0xE00
// RQ14 - auxiliary unit instruction while unit unavailable raises interrupt
// RQ15 - interval timer interrupt needs status, enable and external enable
// RQ16 - fixed variant base 0x000n_nnnn or 0xFFFF_nnnn by prefix select
// RQ17 - programmable variant adds offset register to base prefix
// RQ18 - entry saves return address and state word; return restores them
// RQ19 - untabled types only in programmable variant, own offset register
module cev_exc_unit (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire cev_pkg::cev_core_s cin,
  input wire logic fit_tick,
  output cev_pkg::cev_take_s tk,
  output logic [31:0] machine_state_word,
  output logic [31:0] saved_return_address
);
  logic [31:0] saved_machine_state;
  logic [31:0] cfg;
  logic [31:0] data_fault_cause;
  logic [31:0] data_fault_address;
  logic [31:0] syndrome_word;
  logic [31:0] fault_effective_address;
  logic [31:0] vector_base_prefix;
  logic [31:0] timer_status_word;
  logic [31:0] timer_control_word;
  logic [31:0] fp_status_control;
  logic dec_pend;
  logic wr_pend;
  logic [7:0] wr_addr;
  logic [31:0] rd_val;
  logic [31:0] cause;
  logic [31:0] down_counter;
  logic [31:0] down_counter_reload;
  logic [31:0] vor_rd;
  logic [31:0] next_vector;
  logic msb_rise;
  logic reload_evt;
  logic [31:0] msw;

  assign machine_state_word = msw;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // bus slave
  wire ap = hsel & htrans[1] & hready;
  wire wr_msw = wr_pend && wr_addr == cev_pkg::A_MSW;
  wire wr_cfg = wr_pend && wr_addr == cev_pkg::A_CFG;
  wire wr_sra = wr_pend && wr_addr == cev_pkg::A_SRA;
  wire wr_sms = wr_pend && wr_addr == cev_pkg::A_SMS;
  wire wr_dfc = wr_pend && wr_addr == cev_pkg::A_DFC;
  wire wr_dfa = wr_pend && wr_addr == cev_pkg::A_DFA;
  wire wr_syn = wr_pend && wr_addr == cev_pkg::A_SYN;
  wire wr_fea = wr_pend && wr_addr == cev_pkg::A_FEA;
  wire wr_vbp = wr_pend && wr_addr == cev_pkg::A_VBP;
  wire wr_dcnt = wr_pend && wr_addr == cev_pkg::A_DCNT;
  wire wr_drld = wr_pend && wr_addr == cev_pkg::A_DRLD;
  wire wr_tsw = wr_pend && wr_addr == cev_pkg::A_TSW;
  wire wr_tcw = wr_pend && wr_addr == cev_pkg::A_TCW;
  wire wr_fsc = wr_pend && wr_addr == cev_pkg::A_FSC;
  wire wr_vor = wr_pend && cev_pkg::vor_hit(wr_addr);

  always_comb begin
    case (haddr[7:0])
      cev_pkg::A_MSW: rd_val = msw;
      cev_pkg::A_CFG: rd_val = cfg;
      cev_pkg::A_SRA: rd_val = saved_return_address;
      cev_pkg::A_SMS: rd_val = saved_machine_state;
      cev_pkg::A_DFC: rd_val = data_fault_cause;
      cev_pkg::A_DFA: rd_val = data_fault_address;
      cev_pkg::A_SYN: rd_val = syndrome_word;
      cev_pkg::A_FEA: rd_val = fault_effective_address;
      cev_pkg::A_VBP: rd_val = vector_base_prefix;
      cev_pkg::A_DCNT: rd_val = down_counter;
      cev_pkg::A_DRLD: rd_val = down_counter_reload;
      cev_pkg::A_TSW: rd_val = timer_status_word;
      cev_pkg::A_TCW: rd_val = timer_control_word;
      cev_pkg::A_FSC: rd_val = fp_status_control;
      cev_pkg::A_LVA: rd_val = tk.vector;
      default: rd_val = cev_pkg::vor_hit(haddr[7:0]) ? vor_rd : '0;
    endcase
  end

  // read data is sampled at the address phase, so a read right behind
  // a write to the same register returns the old value
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= '0;
      hrdata <= '0;
    end else begin
      wr_pend <= ap & hwrite;
      wr_addr <= haddr[7:0];
      if (ap && !hwrite) begin
        hrdata <= rd_val;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // exception conditions
  wire prog_var = cfg[cev_pkg::CF_PROG];
  wire rt = cin.retire;
  wire ev_align = rt & cin.align_fault;  // see RQ1
  wire ev_aux = rt & cin.aux_instr & prog_var & cfg[cev_pkg::CF_AUX] &
                ~cfg[cev_pkg::CF_AUXAV];  // see RQ14 RQ19
  wire ev_fpun = rt & cin.fp_instr & ~msw[cev_pkg::MS_FP];  // see RQ8
  wire fe_on = msw[cev_pkg::MS_FE0] | msw[cev_pkg::MS_FE1];
  wire ev_fpen = rt & cin.fp_instr & fe_on &
                 fp_status_control[cev_pkg::FS_FEX];  // see RQ2
  wire ev_mtfs = rt & cin.mtfs_both & ~prog_var;  // see RQ6
  wire ev_unimpl = rt & cin.unimpl & prog_var;  // see RQ7
  wire ev_ill = rt & (cin.illegal | (cin.opt_absent & ~cin.opt_nop)) &
                ~ev_unimpl;  // see RQ3 RQ7
  wire ev_priv = rt & cin.priv_instr & msw[cev_pkg::MS_USER];  // see RQ4
  wire ev_trap = rt & cin.trap_hit;  // see RQ5
  wire ev_prog = ev_fpen | ev_mtfs | ev_ill | ev_unimpl | ev_priv | ev_trap;
  wire ev_sc = rt & cin.syscall;  // see RQ11
  wire ev_fpa = rt & cin.fp_assist & cfg[cev_pkg::CF_FPA];  // see RQ13
  wire sync_any = ev_align | ev_aux | ev_fpun | ev_prog | ev_sc | ev_fpa;
  wire tr_hit = msw[cev_pkg::MS_SE] | (msw[cev_pkg::MS_BE] & cin.branch);
  wire ev_trace = rt & ~sync_any & cfg[cev_pkg::CF_TRACE] & tr_hit;  // see RQ12
  // asynchronous ones wait out a return so the restored state is not lost
  wire async_ok = ~(rt & cin.rfi) & msw[cev_pkg::MS_EE];
  wire ev_dec = dec_pend & async_ok;  // see RQ9
  wire ev_fit = prog_var & timer_status_word[cev_pkg::TS_FIS] &
                timer_control_word[cev_pkg::TC_FIE] & async_ok;  // see RQ15 RQ19
  wire take_now = sync_any | ev_trace | ev_dec | ev_fit;
  wire do_rfi = rt & cin.rfi & ~take_now;

  wire cev_pkg::cev_vec_e next_kind =
    ev_align ? cev_pkg::VK_ALIGN :
    ev_aux ? cev_pkg::VK_AUXUN :
    ev_fpun ? cev_pkg::VK_FPUN :
    ev_prog ? cev_pkg::VK_PROG :
    ev_sc ? cev_pkg::VK_SC :
    ev_fpa ? cev_pkg::VK_FPA :
    ev_trace ? cev_pkg::VK_TRACE :
    ev_dec ? cev_pkg::VK_DEC : cev_pkg::VK_FIT;

  wire rec_align = ev_align;
  wire rec_prog = ~ev_align & ~ev_aux & ~ev_fpun & ev_prog;
  wire ret_next = (next_kind == cev_pkg::VK_SC) |
                  (next_kind == cev_pkg::VK_TRACE) |
                  (((next_kind == cev_pkg::VK_DEC) |
                    (next_kind == cev_pkg::VK_FIT)) & rt);
  wire [31:0] ret_addr = ret_next ? cin.next_pc : cin.pc;

  always_comb begin
    cause = '0;
    cause[cev_pkg::CS_ALIGN] = rec_align;
    cause[cev_pkg::CS_FPEN] = ev_fpen | ev_mtfs;
    cause[cev_pkg::CS_ILL] = ev_ill;
    cause[cev_pkg::CS_PRIV] = ev_priv;
    cause[cev_pkg::CS_TRAP] = ev_trap;
    cause[cev_pkg::CS_UNIMPL] = ev_unimpl;
  end

  ////////////////////////////////////////////////////////////////////////////
  // state save and cause records; hardware updates beat software writes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tk <= '0;
      msw <= cev_pkg::MSW_RESET;
      saved_return_address <= '0;
      saved_machine_state <= '0;
    end else begin
      tk.take <= take_now;
      if (take_now) begin
        tk.kind <= next_kind;
        tk.vector <= next_vector;
        saved_return_address <= ret_addr;  // see RQ18
        saved_machine_state <= msw;  // see RQ18
        msw <= msw & ~cev_pkg::MSW_TAKE_CLR;
      end else if (do_rfi) begin
        msw <= saved_machine_state;  // see RQ18
      end else begin
        if (wr_msw) msw <= hwdata;
        if (wr_sra) saved_return_address <= hwdata;
        if (wr_sms) saved_machine_state <= hwdata;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      data_fault_cause <= '0;
      data_fault_address <= '0;
      syndrome_word <= '0;
      fault_effective_address <= '0;
    end else if (take_now && (rec_align || rec_prog)) begin
      if (prog_var) begin
        syndrome_word <= cause;  // see RQ1 RQ7
        if (rec_align) fault_effective_address <= cin.ea;
      end else begin
        data_fault_cause <= cause;  // see RQ1 RQ6
        if (rec_align) data_fault_address <= cin.ea;
      end
    end else begin
      if (wr_dfc) data_fault_cause <= hwdata;
      if (wr_dfa) data_fault_address <= hwdata;
      if (wr_syn) syndrome_word <= hwdata;
      if (wr_fea) fault_effective_address <= hwdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // plain control and timer status
  wire [31:0] ts_set = ({31'h0, reload_evt} << cev_pkg::TS_DEC) |
                       ({31'h0, fit_tick} << cev_pkg::TS_FIS);
  wire [31:0] ts_clr = wr_tsw ? hwdata : '0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg <= cev_pkg::CFG_RESET;
      vector_base_prefix <= '0;
      timer_control_word <= '0;
      fp_status_control <= '0;
      timer_status_word <= '0;
      dec_pend <= 1'b0;
    end else begin
      if (wr_cfg) cfg <= hwdata;
      if (wr_vbp) vector_base_prefix <= hwdata;
      if (wr_tcw) timer_control_word <= hwdata;
      if (wr_fsc) fp_status_control <= hwdata;
      // write one to clear, a new event wins
      timer_status_word <= (timer_status_word & ~ts_clr) | ts_set;  // see RQ10
      if (msb_rise) begin
        dec_pend <= 1'b1;  // see RQ9
      end else if (take_now && next_kind == cev_pkg::VK_DEC) begin
        dec_pend <= 1'b0;
      end
    end
  end

  cev_down_counter #(
    .W(cev_pkg::XLEN)
  ) u_cnt (
    .hclk(hclk),
    .hresetn(hresetn),
    .prog_var(prog_var),
    .wr_cnt(wr_dcnt),
    .wr_rld(wr_drld),
    .wdata(hwdata),
    .cnt(down_counter),
    .rld(down_counter_reload),
    .msb_rise(msb_rise),
    .reload_evt(reload_evt)
  );

  cev_vector_gen #(
    .N(cev_pkg::NVEC)
  ) u_vec (
    .hclk(hclk),
    .hresetn(hresetn),
    .wr_en(wr_vor),
    .wr_idx(wr_addr[5:2]),
    .wdata(hwdata),
    .rd_idx(haddr[5:2]),
    .rd_data(vor_rd),
    .prog_var(prog_var),
    .ip(msw[cev_pkg::MS_IP]),
    .base_prefix(vector_base_prefix),
    .kind(next_kind),
    .vector(next_vector)
  );

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_align;
    rt && cin.align_fault;
  endsequence
  sequence s_dec_wait;
    msb_rise ##1 (dec_pend && !async_ok);
  endsequence

  align_take_a: assert property (s_align |=> tk.take &&  // see RQ1
    tk.kind == cev_pkg::VK_ALIGN &&
    (fault_effective_address == $past(cin.ea) ||
     data_fault_address == $past(cin.ea)))
    else $error("alignment fault not vectored");
  fpen_prog_a: assert property (rt && cin.fp_instr && fe_on &&  // see RQ2
    msw[cev_pkg::MS_FP] && fp_status_control[cev_pkg::FS_FEX] &&
    !ev_align && !ev_aux |=> tk.take && tk.kind == cev_pkg::VK_PROG)
    else $error("fp enabled exception missed");
  priv_cause_a: assert property (ev_priv && !ev_align &&  // see RQ4
    !ev_aux && !ev_fpun |=> tk.kind == cev_pkg::VK_PROG &&
    (syndrome_word[cev_pkg::CS_PRIV] ||
     data_fault_cause[cev_pkg::CS_PRIV]))
    else $error("privileged cause not recorded");
  fpun_vec_a: assert property (rt && cin.fp_instr &&  // see RQ8
    !msw[cev_pkg::MS_FP] && !ev_align && !ev_aux && !prog_var &&
    !msw[cev_pkg::MS_IP] |=> tk.vector == 32'h0000_0800)
    else $error("fp unavailable vector wrong");
  dec_pending_a: assert property (s_dec_wait |=> dec_pend)  // see RQ9
    else $error("counter interrupt lost while masked");
  reload_step_a: assert property (prog_var && !wr_dcnt &&  // see RQ10
    down_counter == 32'h1 |=> down_counter == $past(down_counter_reload)
    ##1 timer_status_word[cev_pkg::TS_DEC])
    else $error("counter reload missing");
  sc_vec_a: assert property (ev_sc && !ev_align &&  // see RQ11 RQ16
    !ev_aux && !ev_fpun && !ev_prog && !prog_var && msw[cev_pkg::MS_IP]
    |=> tk.vector == 32'hFFFF_0C00 &&
    saved_return_address == $past(cin.next_pc))
    else $error("system call vector wrong");
  fit_gate_a: assert property (tk.take &&  // see RQ15 RQ19
    tk.kind == cev_pkg::VK_FIT |-> $past(prog_var) &&
    $past(msw[cev_pkg::MS_EE]) && $past(timer_control_word[cev_pkg::TC_FIE])
    && $past(timer_status_word[cev_pkg::TS_FIS]))
    else $error("interval timer taken ungated");
  state_save_a: assert property (take_now |=> tk.take &&  // see RQ18
    saved_machine_state == $past(msw) &&
    !msw[cev_pkg::MS_EE])
    else $error("state not saved on entry");
endmodule

// >>> pkg/cev_pkg.sv
// Purpose: shared constants, types and helpers of the exception vectoring unit
// Assumes: 32-bit effective addresses, one core clock
// Notes: register map sits in the low byte of the slave window
package cev_pkg;
  localparam int XLEN = 32;
  localparam int NVEC = 9;

  typedef enum logic [3:0] {
    VK_ALIGN = 4'h0,
    VK_PROG = 4'h1,
    VK_FPUN = 4'h2,
    VK_DEC = 4'h3,
    VK_SC = 4'h4,
    VK_TRACE = 4'h5,
    VK_FPA = 4'h6,
    VK_AUXUN = 4'h7,
    VK_FIT = 4'h8
  } cev_vec_e;

  ////////////////////////////////////////////////////////////////////////////
  // fixed vector offsets and bases
  localparam logic [11:0] OFF_ALIGN = 12'h600;
  localparam logic [11:0] OFF_PROG = 12'h700;
  localparam logic [11:0] OFF_FPUN = 12'h800;
  localparam logic [11:0] OFF_DEC = 12'h900;
  localparam logic [11:0] OFF_SC = 12'hC00;
  localparam logic [11:0] OFF_TRACE = 12'hD00;
  localparam logic [11:0] OFF_FPA = 12'hE00;
  localparam logic [11:0] OFF_NONE = 12'h000;
  localparam logic [31:0] BASE_LOW = 32'h0000_0000;
  localparam logic [31:0] BASE_HIGH = 32'hFFFF_0000;

  ////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int MS_FE0 = 0;
  localparam int MS_FE1 = 1;
  localparam int MS_FP = 2;
  localparam int MS_EE = 3;
  localparam int MS_SE = 4;
  localparam int MS_BE = 5;
  localparam int MS_IP = 6;
  localparam int MS_USER = 7;
  localparam logic [31:0] MSW_RESET = 32'h0000_0000;
  // external enable, single step, branch trace, user cleared on entry
  localparam logic [31:0] MSW_TAKE_CLR = 32'h0000_00B8;
  localparam int CF_PROG = 0;
  localparam int CF_TRACE = 1;
  localparam int CF_FPA = 2;
  localparam int CF_AUX = 3;
  localparam int CF_AUXAV = 4;
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;
  localparam int CS_ALIGN = 0;
  localparam int CS_FPEN = 1;
  localparam int CS_ILL = 2;
  localparam int CS_PRIV = 3;
  localparam int CS_TRAP = 4;
  localparam int CS_UNIMPL = 5;
  localparam int TS_DEC = 0;
  localparam int TS_FIS = 1;
  localparam int TC_FIE = 0;
  localparam int FS_FEX = 0;

  ////////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [7:0] A_MSW = 8'h00;
  localparam logic [7:0] A_CFG = 8'h04;
  localparam logic [7:0] A_SRA = 8'h08;
  localparam logic [7:0] A_SMS = 8'h0C;
  localparam logic [7:0] A_DFC = 8'h10;
  localparam logic [7:0] A_DFA = 8'h14;
  localparam logic [7:0] A_SYN = 8'h18;
  localparam logic [7:0] A_FEA = 8'h1C;
  localparam logic [7:0] A_VBP = 8'h20;
  localparam logic [7:0] A_DCNT = 8'h24;
  localparam logic [7:0] A_DRLD = 8'h28;
  localparam logic [7:0] A_TSW = 8'h2C;
  localparam logic [7:0] A_TCW = 8'h30;
  localparam logic [7:0] A_FSC = 8'h34;
  localparam logic [7:0] A_LVA = 8'h38;
  localparam logic [1:0] A_VOR_HI = 2'h1;

  typedef struct packed {
    logic retire;
    logic [31:0] pc;
    logic [31:0] next_pc;
    logic [31:0] ea;
    logic align_fault;
    logic fp_instr;
    logic mtfs_both;
    logic illegal;
    logic opt_absent;
    logic opt_nop;
    logic unimpl;
    logic priv_instr;
    logic trap_hit;
    logic syscall;
    logic branch;
    logic fp_assist;
    logic aux_instr;
    logic rfi;
  } cev_core_s;

  typedef struct packed {
    logic take;
    cev_vec_e kind;
    logic [31:0] vector;
  } cev_take_s;

  function automatic logic [11:0] fixed_off(cev_vec_e k);
    case (k)
      VK_ALIGN: return OFF_ALIGN;
      VK_PROG: return OFF_PROG;
      VK_FPUN: return OFF_FPUN;
      VK_DEC: return OFF_DEC;
      VK_SC: return OFF_SC;
      VK_TRACE: return OFF_TRACE;
      VK_FPA: return OFF_FPA;
      default: return OFF_NONE;
    endcase
  endfunction

  function automatic logic [31:0] fixed_vec(logic ip, logic [11:0] off);
    return (ip ? BASE_HIGH : BASE_LOW) + {20'h0_0000, off};
  endfunction

  function automatic logic vor_hit(logic [7:0] a);
    return a[7:6] == A_VOR_HI && a[5:2] < 4'(NVEC) && a[1:0] == 2'h0;
  endfunction
endpackage

// >>> hw/cev_down_counter.sv
// Purpose: down-counter with optional auto-reload
// Assumes: counts one step per core clock
// Notes: msb_rise and reload_evt are one-cycle pulses
`timescale 1ns/1ns
module cev_down_counter #(
  parameter int W = 32
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic prog_var,
  input wire logic wr_cnt,
  input wire logic wr_rld,
  input wire logic [W-1:0] wdata,
  output logic [W-1:0] cnt,
  output logic [W-1:0] rld,
  output logic msb_rise,
  output logic reload_evt
);
  wire at_one = cnt == W'(1);
  wire at_zero = cnt == '0;
  // a software write beats the reload in the same cycle
  wire do_reload = prog_var & at_one & ~wr_cnt;
  wire [W-1:0] dec_val = cnt - W'(1);
  // programmable variant parks at zero when the reload value is zero
  wire [W-1:0] next_cnt = wr_cnt ? wdata :
                          do_reload ? rld :  // see RQ10
                          (prog_var & at_zero) ? cnt : dec_val;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt <= '0;
      rld <= '0;
      msb_rise <= 1'b0;
      reload_evt <= 1'b0;
    end else begin
      cnt <= next_cnt;
      if (wr_rld) begin
        rld <= wdata;
      end
      msb_rise <= ~cnt[W-1] & next_cnt[W-1];  // see RQ9
      reload_evt <= do_reload;
    end
  end
endmodule

// >>> hw/cev_vector_gen.sv
// Purpose: handler address formation and per-type offset registers
// Assumes: kind index below N
// Notes: vector output is combinational; the caller registers it
`timescale 1ns/1ns
module cev_vector_gen #(
  parameter int N = cev_pkg::NVEC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic wr_en,
  input wire logic [3:0] wr_idx,
  input wire logic [31:0] wdata,
  input wire logic [3:0] rd_idx,
  output logic [31:0] rd_data,
  input wire logic prog_var,
  input wire logic ip,
  input wire logic [31:0] base_prefix,
  input wire cev_pkg::cev_vec_e kind,
  output logic [31:0] vector
);
  logic [31:0] vor [N];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < N; i++) begin
        vor[i] <= '0;
      end
    end else if (wr_en && wr_idx < 4'(N)) begin
      vor[wr_idx] <= wdata;
    end
  end

  assign rd_data = (rd_idx < 4'(N)) ? vor[rd_idx] : '0;
  // untabled types only occur in the programmable variant: see RQ19
  assign vector = prog_var ? base_prefix + vor[kind] :  // see RQ17
                  cev_pkg::fixed_vec(ip, cev_pkg::fixed_off(kind));  // see RQ16
endmodule

// >>> sim/cev_core_model.sv
// Purpose: core pipeline stand-in presenting one retiring instruction
// Assumes: flags follow cev_core_s order, align_fault at bit 13
// Notes: pc follows each taken vector, so return addresses move
`timescale 1ns/1ns
module cev_core_model (
  input wire logic hclk,
  input wire logic go,
  input wire logic [13:0] flags,
  input wire cev_pkg::cev_take_s tk,
  output cev_pkg::cev_core_s cin
);
  logic [31:0] pc = 32'h0000_1000;
  // flags zeroed when idle so stale events never look live
  assign cin = {go, pc, pc + 32'h4, pc ^ 32'h3, go ? flags : 14'h0};
  always @(posedge hclk) begin
    if (tk.take) begin
      pc <= tk.vector;
    end else if (go) begin
      pc <= pc + 32'h4;
    end
  end
endmodule

// >>> sim/cev_exc_unit_tb.sv
// Purpose: self-checking bench of the exception vectoring unit
// Assumes: zero wait state slave, take one edge after the event
// Notes: ordinary events as table rows, timers and save state by hand
`timescale 1ns/1ns
module cev_exc_unit_tb;
  typedef struct packed {
    logic [4:0] cfg;
    logic [7:0] msw;
    logic [13:0] fl;
    logic [3:0] k;
    logic [11:0] off;
  } cev_row_s;
  localparam logic [31:0] PFX = 32'h1000_0000;
  logic hclk, hresetn, hsel, hwrite, go, fit_tick, hreadyout, hresp;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, sra, msw_o, r, ea, v;
  logic [13:0] flags;
  cev_pkg::cev_core_s cin;
  cev_pkg::cev_take_s tk;
  cev_row_s rows [17];
  int failures, comparisons;

  cev_exc_unit dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .cin(cin), .fit_tick(fit_tick),
    .tk(tk), .machine_state_word(msw_o), .saved_return_address(sra));
  cev_core_model mdl_u (.hclk(hclk), .go(go), .flags(flags), .tk(tk),
    .cin(cin));

  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task automatic conclude;
    if (failures == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    r = hrdata;
  endtask

  // take must show exactly one edge after the retiring cycle
  task automatic fire(input logic [13:0] f, input logic [3:0] k,
                      input logic [31:0] e);
    go <= 1'b1;
    flags <= f;
    @(posedge hclk);
    go <= 1'b0;
    #1;
    chk({31'h0, tk.take}, {31'h0, k != 4'hF});
    if (k != 4'hF) begin
      chk(32'(tk.kind), {28'h0, k});
      chk(tk.vector, e);
    end
    @(posedge hclk);
  endtask

  task automatic wait_take(input logic [3:0] k, input logic [31:0] e);
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      #1;
      n++;
    end while (tk.take !== 1'b1 && n < 8);
    chk({31'h0, tk.take}, 32'h1);
    chk(32'(tk.kind), {28'h0, k});
    chk(tk.vector, e);
    @(posedge hclk);
  endtask

  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  // generous bound: the whole run is under two hundred cycles
  initial begin
    repeat (5000) @(posedge hclk);
    failures++;
    conclude;
  end

  initial begin
    rows = '{
      '{5'h00, 8'h00, 14'h2000, 4'h0, 12'h600},
      '{5'h00, 8'h05, 14'h1000, 4'h1, 12'h700},
      '{5'h00, 8'h04, 14'h1000, 4'hF, 12'h000},
      '{5'h00, 8'h00, 14'h0400, 4'h1, 12'h700},
      '{5'h00, 8'h00, 14'h0200, 4'h1, 12'h700},
      '{5'h00, 8'h00, 14'h0300, 4'hF, 12'h000},
      '{5'h00, 8'h80, 14'h0040, 4'h1, 12'h700},
      '{5'h00, 8'h00, 14'h0040, 4'hF, 12'h000},
      '{5'h00, 8'h00, 14'h0020, 4'h1, 12'h700},
      '{5'h00, 8'h00, 14'h0800, 4'h1, 12'h700},
      '{5'h00, 8'h00, 14'h1000, 4'h2, 12'h800},
      '{5'h00, 8'h40, 14'h0010, 4'h4, 12'hC00},
      '{5'h02, 8'h10, 14'h0000, 4'h5, 12'hD00},
      '{5'h02, 8'h20, 14'h0008, 4'h5, 12'hD00},
      '{5'h04, 8'h00, 14'h0004, 4'h6, 12'hE00},
      '{5'h09, 8'h00, 14'h0002, 4'h7, 12'h000},
      '{5'h01, 8'h00, 14'h0480, 4'h1, 12'h000}
    };
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    go = 1'b0;
    flags = 14'h0;
    fit_tick = 1'b0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(1'b0, cev_pkg::A_MSW, 32'h0);
    chk(r, 32'h0);
    chk({30'h0, hresp, hreadyout}, 32'h1);
    bus(1'b1, cev_pkg::A_FSC, 32'h1);
    bus(1'b1, cev_pkg::A_VBP, PFX);
    for (int i = 0; i < 9; i++) begin
      bus(1'b1, 8'h40 + 8'(4 * i), 32'(16 * i));
    end
    for (int i = 0; i < 17; i++) begin
      bus(1'b1, cev_pkg::A_CFG, {27'h0, rows[i].cfg});
      bus(1'b1, cev_pkg::A_MSW, {24'h0, rows[i].msw});
      v = rows[i].cfg[0] ? PFX + {24'h0, rows[i].k, 4'h0} :
          {rows[i].msw[6] ? 16'hFFFF : 16'h0000, 4'h0, rows[i].off};
      fire(rows[i].fl, rows[i].k, v);
    end
    // unimplemented wins over illegal in the syndrome
    bus(1'b0, cev_pkg::A_SYN, 32'h0);
    chk(r, 32'h20);
    // cause and faulting address kept for the handler
    bus(1'b1, cev_pkg::A_CFG, 32'h0);
    bus(1'b1, cev_pkg::A_MSW, 32'h0);
    ea = mdl_u.pc ^ 32'h3;
    fire(14'h2000, 4'h0, 32'h600);
    bus(1'b0, cev_pkg::A_DFC, 32'h0);
    chk(r, 32'h1);
    bus(1'b0, cev_pkg::A_DFA, 32'h0);
    chk(r, ea);
    // wrap after reset left the counter pending behind external enable
    bus(1'b1, cev_pkg::A_MSW, 32'h08);
    wait_take(4'h3, 32'h900);
    chk(msw_o, 32'h0);
    bus(1'b1, cev_pkg::A_MSW, 32'h48);
    ea = mdl_u.pc + 32'h4;
    fire(14'h0010, 4'h4, 32'hFFFF_0C00);
    chk(sra, ea);
    chk(msw_o, 32'h40);
    fire(14'h0001, 4'hF, 32'h0);
    chk(msw_o, 32'h48);
    bus(1'b1, cev_pkg::A_CFG, 32'h1);
    bus(1'b1, cev_pkg::A_DRLD, 32'h55);
    bus(1'b1, cev_pkg::A_DCNT, 32'h3);
    repeat (6) @(posedge hclk);
    bus(1'b0, cev_pkg::A_TSW, 32'h0);
    chk(r, 32'h1);
    bus(1'b0, cev_pkg::A_DCNT, 32'h0);
    // reloaded at the third edge after the write, then five more steps
    chk(r, 32'h50);
    // status alone must not take while its enable is off
    fit_tick <= 1'b1;
    @(posedge hclk);
    fit_tick <= 1'b0;
    repeat (3) @(posedge hclk);
    chk(32'(tk.kind), 32'h4);
    bus(1'b1, cev_pkg::A_TCW, 32'h1);
    wait_take(4'h8, PFX + 32'h80);
    // reset in mid-run drops saved state and the last vector
    hresetn <= 1'b0;
    @(posedge hclk);
    hresetn <= 1'b1;
    #1;
    chk(sra, 32'h0);
    chk(tk.vector, 32'h0);
    chk({31'h0, tk.take}, 32'h0);
    @(posedge hclk);
    bus(1'b1, 8'h3C, 32'hA5);
    bus(1'b0, 8'h3C, 32'h0);
    chk(r, 32'h0);
    conclude;
  end
endmodule
